// ---- bench/imac_bench.sv ----
// self-checking bench for the arbitration core
`timescale 1ns/1ps
`default_nettype none
`include "imac_map.svh"
module imac_bench;
	import imac_pkg::*;
	// ==========
	// wiring
	logic         clk;
	logic         rst;
	imac_wb_req_t req;
	imac_wb_rsp_t rsp;
	logic         scl_oe_n;
	logic         sda_oe_n;
	logic         scl_drv;
	logic         sda_drv;
	logic         sleep;
	logic         irq;
	logic         wake;
	logic [1:0]   cmd;
	logic         sda_pull;
	logic         scl_pull;
	wire          scl_line;
	wire          sda_line;
	int           failures;
	int           n_compared;
	logic [31:0]  x;
	// pulled-up open-drain lines
	assign scl_line = scl_oe_n && !scl_pull;
	assign sda_line = sda_oe_n && !sda_pull;
	imac_top uut (
		.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp),
		.scl_i(scl_line), .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n),
		.sda_i(sda_line), .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n),
		.sleep_i(sleep), .port_irq_o(irq), .wake_o(wake)
	);
	imac_peer peer (.cmd_i(cmd), .sda_pull_o(sda_pull), .scl_pull_o(scl_pull));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ==========
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		req <= '{1'b1, 1'b1, we, adr, 4'h1, dat};
		do begin
			@(posedge clk);
		end while (rsp.ack !== 1'b1);
		x = rsp.dat;
		req <= '0;
		@(posedge clk);
	endtask
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			wb(1'b0, `IMAC_ADR_FLAGS, 32'h0);
			n++;
		end while (x[b] !== 1'b1 && n < 500);
		check(x[b], 1'b1);
	endtask
	task automatic wait_pin(input bit on_sda, input logic lvl, output int n);
		n = 0;
		while ((on_sda ? sda_oe_n : scl_oe_n) !== lvl && n < 400) begin
			@(posedge clk);
			n++;
		end
		check(n < 400, 1'b1);
	endtask
	task automatic wrap_up();
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x, 32'h0);
		check({sda_oe_n, scl_oe_n, irq}, 3'h6);
		wb(1'b0, 8'h3c, 32'h0);
		check(x, 32'h0);
		wb(1'b1, `IMAC_ADR_RELOAD, 32'h4);
		wb(1'b1, `IMAC_ADR_CTRL, 32'h3);
	endtask
	task automatic t_foreign();
		sleep <= 1'b1;
		cmd <= 2'h3;
		wait_flag(`IMAC_FLAG_EVT);
		cmd <= 2'h0;
		check({irq, wake}, 2'h3);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x[`IMAC_STAT_STOP], 1'b1);
		sleep <= 1'b0;
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		check(irq, 1'b0);
	endtask
	task automatic t_start();
		int n;
		wb(1'b1, `IMAC_ADR_SEQ, 32'h1);
		wait_pin(1'b1, 1'b0, n);
		check(scl_oe_n, 1'b1);
		wait_pin(1'b0, 1'b0, n);
		check(n >= 4, 1'b1);
		wait_flag(`IMAC_FLAG_EVT);
		wb(1'b0, `IMAC_ADR_SEQ, 32'h0);
		check(x[`IMAC_SEQ_START], 1'b0);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
	endtask
	task automatic t_collide();
		wb(1'b1, `IMAC_ADR_BUF, 32'h3f);
		wb(1'b1, `IMAC_ADR_BUF, 32'h55);
		cmd <= 2'h1;
		wait_flag(`IMAC_FLAG_BCL);
		check(x[`IMAC_FLAG_WRITE_COLLISION_FLAG], 1'b1);
		check({sda_oe_n, scl_oe_n}, 2'h3);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x[`IMAC_STAT_FULL], 1'b0);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		cmd <= 2'h0;
		wait_flag(`IMAC_FLAG_EVT);
		check(x[`IMAC_FLAG_BCL], 1'b1);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x[`IMAC_STAT_STOP], 1'b1);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h7);
	endtask
	task automatic t_blocked();
		cmd <= 2'h2;
		repeat (8) @(posedge clk);
		wb(1'b1, `IMAC_ADR_SEQ, 32'h1);
		wait_flag(`IMAC_FLAG_BCL);
		wb(1'b0, `IMAC_ADR_SEQ, 32'h0);
		check(x[`IMAC_SEQ_START], 1'b0);
		check({sda_oe_n, scl_oe_n}, 2'h3);
		cmd <= 2'h0;
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h7);
	endtask
	task automatic t_restart();
		int n;
		wb(1'b1, `IMAC_ADR_SEQ, 32'h1);
		wait_flag(`IMAC_FLAG_EVT);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		wb(1'b1, `IMAC_ADR_BUF, 32'h7f);
		wait_pin(1'b0, 1'b1, n);
		check(sda_oe_n, 1'b0);
		wait_pin(1'b0, 1'b0, n);
		// eight more clock pulses: bits 1 to 7 and the ack bit
		repeat (8) begin
			wait_pin(1'b0, 1'b1, n);
			wait_pin(1'b0, 1'b0, n);
		end
		wb(1'b0, `IMAC_ADR_FLAGS, 32'h0);
		check(x[`IMAC_FLAG_EVT], 1'b1);
	endtask
	task automatic t_seq();
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		wb(1'b1, `IMAC_ADR_SEQ, 32'h2);
		wait_flag(`IMAC_FLAG_EVT);
		check(x[`IMAC_FLAG_BCL], 1'b0);
		check({sda_oe_n, scl_oe_n}, 2'h0);
		wb(1'b0, `IMAC_ADR_SEQ, 32'h0);
		check(x[`IMAC_SEQ_RSTART], 1'b0);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		wb(1'b1, `IMAC_ADR_SEQ, 32'h4);
		wait_flag(`IMAC_FLAG_EVT);
		check(x[`IMAC_FLAG_BCL], 1'b0);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x, 32'h10);
		check({sda_oe_n, scl_oe_n}, 2'h3);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		wb(1'b1, `IMAC_ADR_SEQ, 32'h1);
		wait_flag(`IMAC_FLAG_EVT);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h1);
		// other master keeps data low through our stop
		cmd <= 2'h1;
		wb(1'b1, `IMAC_ADR_SEQ, 32'h4);
		wait_flag(`IMAC_FLAG_BCL);
		wb(1'b0, `IMAC_ADR_SEQ, 32'h0);
		check(x[4:0], 5'h0);
		check({sda_oe_n, scl_oe_n}, 2'h3);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h2);
		wb(1'b1, `IMAC_ADR_SEQ, 32'h30);
		wait_flag(`IMAC_FLAG_BCL);
		wb(1'b0, `IMAC_ADR_SEQ, 32'h0);
		check(x[5:0], 6'h20);
		check({sda_oe_n, scl_oe_n}, 2'h3);
		cmd <= 2'h0;
		wait_flag(`IMAC_FLAG_EVT);
		check(x[`IMAC_FLAG_BCL], 1'b1);
		wb(1'b1, `IMAC_ADR_FLAGS, 32'h7);
		sleep <= 1'b1;
		wb(1'b1, `IMAC_ADR_SEQ, 32'h8);
		wait_flag(`IMAC_FLAG_EVT);
		check(wake, 1'b1);
		sleep <= 1'b0;
		wb(1'b0, `IMAC_ADR_BUF, 32'h0);
		check(x, 32'hff);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x[`IMAC_STAT_FULL], 1'b0);
		wb(1'b1, `IMAC_ADR_CTRL, 32'h0);
		wb(1'b0, `IMAC_ADR_STATUS, 32'h0);
		check(x, 32'h0);
		check({sda_oe_n, scl_oe_n}, 2'h3);
	endtask
	// ==========
	// run
	initial begin
		repeat (40000) @(posedge clk);
		check(32'h0, 32'h1);
		wrap_up();
	end
	initial begin
		failures = 0;
		n_compared = 0;
		rst = 1'b1;
		req = '0;
		sleep = 1'b0;
		cmd = 2'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_foreign();
		t_start();
		t_collide();
		t_blocked();
		t_restart();
		t_seq();
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- bench/imac_peer.sv ----
// far-side party of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module imac_peer (
	input  wire logic [1:0] cmd_i,      // 0 free 1 data 2 clock 3 frame
	output logic            sda_pull_o, // pulls data low
	output logic            scl_pull_o  // pulls clock low
);
	// ==========
	// link clock half period of a 160 ns cycle
	localparam time HALF = 80ns;
	// both lines free from time zero
	initial begin
		sda_pull_o = 1'b0;
		scl_pull_o = 1'b0;
	end
	// frame: start, two clock pulses, stop; clock high outside it
	always @(cmd_i) begin
		sda_pull_o = cmd_i == 2'h1;
		scl_pull_o = cmd_i == 2'h2;
		if (cmd_i == 2'h3) begin
			#HALF sda_pull_o = 1'b1;
			repeat (2) begin
				#HALF scl_pull_o = 1'b1;
				#HALF scl_pull_o = 1'b0;
			end
			#HALF sda_pull_o = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/imac_properties.sv ----
// port assertions for the arbitration core
`timescale 1ns/1ps
`default_nettype none
`include "imac_map.svh"
module imac_props
	import imac_pkg::*;
(
	input wire logic                   clk_i,      // core clock
	input wire logic                   rst_i,      // sync reset
	input wire imac_pkg::imac_wb_req_t wb_req_i,   // bus request
	input wire imac_pkg::imac_wb_rsp_t wb_rsp_o,   // bus answer
	input wire logic                   scl_i,      // clock line
	input wire logic                   scl_o,      // clock drive
	input wire logic                   scl_oe_n_o, // clock pull
	input wire logic                   sda_i,      // data line
	input wire logic                   sda_o,      // data drive
	input wire logic                   sda_oe_n_o, // data pull
	input wire logic                   sleep_i,    // asleep
	input wire logic                   port_irq_o, // interrupt
	input wire logic                   wake_o      // wake
);
	// ==========
	// helpers
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic req;
	logic rd_flg;
	logic wr_flg;
	logic go_wr;
	logic bcl_reg;
	logic bcl_next;
	assign req    = wb_req_i.cyc && wb_req_i.stb;
	assign rd_flg = wb_rsp_o.ack && !wb_req_i.we
		&& wb_req_i.adr == `IMAC_ADR_FLAGS;
	assign wr_flg = wb_rsp_o.ack && wb_req_i.we
		&& wb_req_i.dat[`IMAC_FLAG_BCL]
		&& wb_req_i.adr == `IMAC_ADR_FLAGS;
	assign go_wr  = req && wb_req_i.we && wb_req_i.sel[0]
		&& wb_req_i.dat[`IMAC_SEQ_START] && wb_req_i.adr == `IMAC_ADR_SEQ;
	// collision flag as software last read it
	always_comb begin
		bcl_next = bcl_reg;
		if (rd_flg)
			bcl_next = wb_rsp_o.dat[`IMAC_FLAG_BCL];
		if (wr_flg)
			bcl_next = 1'b0;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			bcl_reg <= 1'b0;
		else
			bcl_reg <= bcl_next;
	end
	// ==========
	// assertions
	a_ack_follows: assert property ($rose(req) |=> wb_rsp_o.ack)
		else $error("no answer one cycle after request");
	a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("answer longer than one cycle");
	a_ack_caused: assert property (wb_rsp_o.ack |-> $past(req))
		else $error("answer without request");
	a_hole_zero: assert property (wb_rsp_o.ack && !wb_req_i.we
		&& wb_req_i.adr == 8'h3c |-> wb_rsp_o.dat == 32'h0)
		else $error("unmapped read not zero");
	a_reset_idle: assert property ($past(rst_i) |-> sda_oe_n_o
		&& scl_oe_n_o && !port_irq_o && !wb_rsp_o.ack)
		else $error("lines or answer busy after reset");
	a_pins_low_only: assert property (!scl_o && !sda_o)
		else $error("line driven high");
	a_wake_irq: assert property (wake_o == (sleep_i && port_irq_o))
		else $error("wake does not follow interrupt in sleep");
	a_start_blocked: assert property ((!scl_i)[*6] ##0 go_wr
		&& sda_oe_n_o && scl_oe_n_o |=> sda_oe_n_o[*8])
		else $error("start pulled data with clock low");
	a_clock_after_data: assert property ($fell(sda_oe_n_o)
		&& scl_oe_n_o |-> scl_oe_n_o[*4] ##[1:300] !scl_oe_n_o)
		else $error("clock pull not one count after data pull");
	a_bcl_sticky: assert property (rd_flg && bcl_reg
		|-> wb_rsp_o.dat[`IMAC_FLAG_BCL])
		else $error("collision flag cleared without software");
	c_start: cover property ($fell(sda_oe_n_o) && scl_oe_n_o);
	c_blocked: cover property (go_wr && !scl_i);
	c_bcl_read: cover property (rd_flg && wb_rsp_o.dat[`IMAC_FLAG_BCL]);
endmodule

bind imac_top imac_props chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .sleep_i(sleep_i),
	.port_irq_o(port_irq_o), .wake_o(wake_o)
);
`default_nettype wire

// ---- core/imac_map.svh ----
// register offsets, field positions, reset values for the arbitration core
`ifndef IMAC_MAP_SVH
`define IMAC_MAP_SVH

// ==========================================================
// register byte offsets
`define IMAC_ADR_CTRL     8'h00
`define IMAC_ADR_SEQ      8'h04
`define IMAC_ADR_STATUS   8'h08
`define IMAC_ADR_FLAGS    8'h0c
`define IMAC_ADR_BUF      8'h10
`define IMAC_ADR_RELOAD   8'h14

// ==========================================================
// control register fields
`define IMAC_CTRL_EN      0
`define IMAC_CTRL_IE      1

// ==========================================================
// sequence control register fields
`define IMAC_SEQ_START    0
`define IMAC_SEQ_RSTART   1
`define IMAC_SEQ_STOP     2
`define IMAC_SEQ_RCV      3
`define IMAC_SEQ_ACK      4
`define IMAC_SEQ_ACKDATA  5
`define IMAC_SEQ_ACKSTAT  6

// ==========================================================
// port status register fields
`define IMAC_STAT_FULL    0
`define IMAC_STAT_START   3
`define IMAC_STAT_STOP    4
`define IMAC_STAT_BUSY    5

// ==========================================================
// event flag register fields, write one to clear
`define IMAC_FLAG_EVT     0
`define IMAC_FLAG_BCL     1
`define IMAC_FLAG_WRITE_COLLISION_FLAG    2

// ==========================================================
// reset values and counts
`define IMAC_RST_RELOAD   7'h00
`define IMAC_RST_BYTE     8'h00
`define IMAC_RST_WORD     32'h0000_0000
`define IMAC_ACK_BIT      4'h8
`define IMAC_LAST_BIT     4'h7

`endif

// ---- core/imac_pkg.sv ----
// types shared by the arbitration core and its bench
package imac_pkg;

	// ==========================================================
	// sequencer states
	typedef enum logic [4:0] {
		ST_IDLE,
		ST_S_CHK,
		ST_S_CNT1,
		ST_S_CNT2,
		ST_R_REL,
		ST_R_CNT1,
		ST_R_SCLH,
		ST_R_CNT2,
		ST_R_CNT3,
		ST_P_SDAL,
		ST_P_SCLH,
		ST_P_CNT1,
		ST_P_CNT2,
		ST_B_LOW,
		ST_B_REL,
		ST_B_HIGH
	} imac_state_t;

	typedef enum logic [1:0] {
		XF_TX,
		XF_RX,
		XF_ACK
	} imac_xfer_t;

	// ==========================================================
	// wishbone carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} imac_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} imac_wb_rsp_t;

endpackage

// ---- core/imac_top.sv ----
// multi-master arbitration and collision core of a two-wire master port
`timescale 1ns/1ps
`default_nettype none
`include "imac_map.svh"

// Function
// - events wake sleeping processor when interrupt enabled
// - reset disables port, ends any transfer
// - start/stop seen cleared by reset, disable
// - bus stop raises port interrupt
// - released one sampled low sets collision, idles
// - collision checked in address, data, sequences
// - transmit collision clears full, releases lines
// - sequence collision aborts, releases, clears enables
// - keep watching bus, stop sets event
// - buffer write restarts at first bit
// - line low at start begin collides
// - start count from reload; clock low collides
// - data low early resets count, drives early
// - second start count, then clock low
// - repeated start: count, release, check data
// - clock falling before data asserted collides
// - timeout drives data low, then clock
// - stop: data low after timeout collides
// - stop: clock low before data release collides
// - buffer write while busy sets write collision
module imac_top
	import imac_pkg::*;
(
	input  wire logic                  clk_i,      // 200 MHz core clock
	input  wire logic                  rst_i,      // sync reset, high
	input  wire imac_pkg::imac_wb_req_t wb_req_i,  // wishbone request
	output var  imac_pkg::imac_wb_rsp_t wb_rsp_o,   // wishbone answer
	input  wire logic                  scl_i,      // clock line level
	output logic                       scl_o,      // clock line drive
	output logic                       scl_oe_n_o, // low pulls clock
	input  wire logic                  sda_i,      // data line level
	output logic                       sda_o,      // data line drive
	output logic                       sda_oe_n_o, // low pulls data
	input  wire logic                  sleep_i,    // processor asleep
	output logic                       port_irq_o, // port interrupt
	output logic                       wake_o      // wake request
);
	import imac_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [2:0]  scl_sy;
		logic [2:0]  sda_sy;
		logic        scl;
		logic        sda;
		imac_state_t st;
		imac_xfer_t  xf;
		logic [6:0]  cnt;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic [7:0]  shift_buffer;
		logic        en;
		logic        ie;
		logic [6:0]  rate_reload;
		logic        start_en;
		logic        rstart_en;
		logic        stop_en;
		logic        rcv_en;
		logic        ack_en;
		logic        ack_data;
		logic        ackstat;
		logic        buffer_full_flag;
		logic        start_seen;
		logic        stop_seen;
		logic        port_event_flag;
		logic        bus_collision_flag;
		logic        write_collision_flag;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic        ack;
		logic [31:0] rdat;
	} imac_regs_t;

	imac_regs_t r_reg;
	imac_regs_t r_next;

	// abort to idle with both lines released
	function automatic imac_regs_t imac_collide(input imac_regs_t v);
		v.bus_collision_flag = 1'b1;
		v.st = ST_IDLE;
		v.scl_oe_n = 1'b1;
		v.sda_oe_n = 1'b1;
		v.buffer_full_flag = 1'b0;
		v.start_en = 1'b0;
		v.rstart_en = 1'b0;
		v.stop_en = 1'b0;
		v.rcv_en = 1'b0;
		v.ack_en = 1'b0;
		return v;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		imac_regs_t  n;
		logic        acc;
		logic        wr;
		logic        rd;
		logic        busy;
		logic        tick;
		logic        stop_ev;
		logic        coll;
		logic        done;
		logic [7:0]  adr;
		logic [31:0] rv;
		n = r_reg;
		acc = wb_req_i.cyc && wb_req_i.stb;
		wr = acc && wb_req_i.we && r_reg.ack && wb_req_i.sel[0];
		rd = acc && !wb_req_i.we && r_reg.ack;
		adr = {wb_req_i.adr[7:2], 2'b00};
		busy = (r_reg.st != ST_IDLE) || r_reg.start_en || r_reg.rstart_en
			|| r_reg.stop_en || r_reg.rcv_en || r_reg.ack_en;
		tick = (r_reg.cnt == 7'h00);
		coll = 1'b0;
		done = 1'b0;
		rv = `IMAC_RST_WORD;
		stop_ev = 1'b0;

		// line sampling, change taken once stages two and three agree
		n.scl_sy = {r_reg.scl_sy[1:0], scl_i};
		n.sda_sy = {r_reg.sda_sy[1:0], sda_i};
		if (r_reg.scl_sy[1] == r_reg.scl_sy[2]) begin
			n.scl = r_reg.scl_sy[2];
		end
		if (r_reg.sda_sy[1] == r_reg.sda_sy[2]) begin
			n.sda = r_reg.sda_sy[2];
		end

		// bus start and stop watch, active even after a collision
		if (r_reg.scl && n.scl && r_reg.sda && !n.sda) begin
			n.start_seen = 1'b1;
			n.stop_seen = 1'b0;
		end
		stop_ev = r_reg.scl && n.scl && !r_reg.sda && n.sda;
		if (stop_ev) begin
			n.stop_seen = 1'b1;
			n.start_seen = 1'b0;
		end

		if (!tick) begin
			n.cnt = r_reg.cnt - 7'h01;
		end

		// ======================================================
		// register bus
		n.ack = acc && !r_reg.ack;
		case (adr)
			`IMAC_ADR_CTRL: begin
				rv[`IMAC_CTRL_EN] = r_reg.en;
				rv[`IMAC_CTRL_IE] = r_reg.ie;
			end
			`IMAC_ADR_SEQ: begin
				rv[`IMAC_SEQ_START] = r_reg.start_en;
				rv[`IMAC_SEQ_RSTART] = r_reg.rstart_en;
				rv[`IMAC_SEQ_STOP] = r_reg.stop_en;
				rv[`IMAC_SEQ_RCV] = r_reg.rcv_en;
				rv[`IMAC_SEQ_ACK] = r_reg.ack_en;
				rv[`IMAC_SEQ_ACKDATA] = r_reg.ack_data;
				rv[`IMAC_SEQ_ACKSTAT] = r_reg.ackstat;
			end
			`IMAC_ADR_STATUS: begin
				rv[`IMAC_STAT_FULL] = r_reg.buffer_full_flag;
				rv[`IMAC_STAT_START] = r_reg.start_seen;
				rv[`IMAC_STAT_STOP] = r_reg.stop_seen;
				rv[`IMAC_STAT_BUSY] = busy;
			end
			`IMAC_ADR_FLAGS: begin
				rv[`IMAC_FLAG_EVT] = r_reg.port_event_flag;
				rv[`IMAC_FLAG_BCL] = r_reg.bus_collision_flag;
				rv[`IMAC_FLAG_WRITE_COLLISION_FLAG] = r_reg.write_collision_flag;
			end
			`IMAC_ADR_BUF: rv[7:0] = r_reg.shift_buffer;
			`IMAC_ADR_RELOAD: rv[6:0] = r_reg.rate_reload;
			default: rv = `IMAC_RST_WORD;
		endcase
		if (!r_reg.ack) begin
			n.rdat = rv;
		end

		if (rd && adr == `IMAC_ADR_BUF && r_reg.st == ST_IDLE) begin
			n.buffer_full_flag = 1'b0;
		end

		if (wr) begin
			case (adr)
				`IMAC_ADR_CTRL: begin
					n.en = wb_req_i.dat[`IMAC_CTRL_EN];
					n.ie = wb_req_i.dat[`IMAC_CTRL_IE];
				end
				`IMAC_ADR_SEQ: begin
					n.ack_data = wb_req_i.dat[`IMAC_SEQ_ACKDATA];
					if (!busy) begin
						n.start_en = wb_req_i.dat[`IMAC_SEQ_START];
						n.rstart_en = wb_req_i.dat[`IMAC_SEQ_RSTART];
						n.stop_en = wb_req_i.dat[`IMAC_SEQ_STOP];
						n.rcv_en = wb_req_i.dat[`IMAC_SEQ_RCV];
						n.ack_en = wb_req_i.dat[`IMAC_SEQ_ACK];
					end
				end
				`IMAC_ADR_FLAGS: begin
					if (wb_req_i.dat[`IMAC_FLAG_EVT]) begin
						n.port_event_flag = 1'b0;
					end
					if (wb_req_i.dat[`IMAC_FLAG_BCL]) begin
						n.bus_collision_flag = 1'b0;
					end
					if (wb_req_i.dat[`IMAC_FLAG_WRITE_COLLISION_FLAG]) begin
						n.write_collision_flag = 1'b0;
					end
				end
				`IMAC_ADR_BUF: begin
					if (busy) begin
						n.write_collision_flag = 1'b1;
					end else begin
						n.shift_buffer = wb_req_i.dat[7:0];
						n.sh = wb_req_i.dat[7:0];
						n.buffer_full_flag = 1'b1;
						n.bitn = 4'h0;
						n.xf = XF_TX;
						n.cnt = r_reg.rate_reload;
						n.scl_oe_n = 1'b0;
						n.st = ST_B_LOW;
					end
				end
				`IMAC_ADR_RELOAD: n.rate_reload = wb_req_i.dat[6:0];
				default: n.ack = n.ack;
			endcase
		end

		// ======================================================
		// sequencer
		case (r_reg.st)
			ST_IDLE: begin
				if (r_reg.start_en) begin
					n.st = ST_S_CHK;
				end else if (r_reg.rstart_en) begin
					n.sda_oe_n = 1'b1;
					n.st = ST_R_REL;
				end else if (r_reg.stop_en) begin
					n.sda_oe_n = 1'b0;
					n.st = ST_P_SDAL;
				end else if (r_reg.rcv_en || r_reg.ack_en) begin
					n.xf = r_reg.rcv_en ? XF_RX : XF_ACK;
					n.bitn = 4'h0;
					n.cnt = r_reg.rate_reload;
					n.scl_oe_n = 1'b0;
					n.st = ST_B_LOW;
				end
			end
			ST_S_CHK: begin
				if (!r_reg.scl || !r_reg.sda) begin
					coll = 1'b1;
				end else begin
					n.cnt = r_reg.rate_reload;
					n.st = ST_S_CNT1;
				end
			end
			ST_S_CNT1: begin
				if (!r_reg.sda || tick) begin
					n.sda_oe_n = 1'b0;
					n.cnt = r_reg.rate_reload;
					n.st = ST_S_CNT2;
				end else if (!r_reg.scl) begin
					coll = 1'b1;
				end
			end
			ST_S_CNT2: begin
				if (tick) begin
					n.scl_oe_n = 1'b0;
					n.start_en = 1'b0;
					done = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_R_REL: begin
				if (r_reg.sda) begin
					n.cnt = r_reg.rate_reload;
					n.st = ST_R_CNT1;
				end
			end
			ST_R_CNT1: begin
				if (tick) begin
					n.scl_oe_n = 1'b1;
					n.st = ST_R_SCLH;
				end
			end
			ST_R_SCLH: begin
				if (r_reg.scl && !r_reg.sda) begin
					coll = 1'b1;
				end else if (r_reg.scl) begin
					n.cnt = r_reg.rate_reload;
					n.st = ST_R_CNT2;
				end
			end
			ST_R_CNT2: begin
				if (!r_reg.scl && r_reg.sda) begin
					coll = 1'b1;
				end else if (tick) begin
					n.sda_oe_n = 1'b0;
					n.cnt = r_reg.rate_reload;
					n.st = ST_R_CNT3;
				end
			end
			ST_R_CNT3: begin
				if (tick) begin
					n.scl_oe_n = 1'b0;
					n.rstart_en = 1'b0;
					done = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_P_SDAL: begin
				if (!r_reg.sda) begin
					n.scl_oe_n = 1'b1;
					n.st = ST_P_SCLH;
				end
			end
			ST_P_SCLH: begin
				if (r_reg.scl) begin
					n.cnt = r_reg.rate_reload;
					n.st = ST_P_CNT1;
				end
			end
			ST_P_CNT1: begin
				if (!r_reg.scl) begin
					coll = 1'b1;
				end else if (tick) begin
					n.sda_oe_n = 1'b1;
					n.cnt = r_reg.rate_reload;
					n.st = ST_P_CNT2;
				end
			end
			ST_P_CNT2: begin
				if (tick && !r_reg.sda) begin
					coll = 1'b1;
				end else if (tick) begin
					n.stop_en = 1'b0;
					done = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_B_LOW: begin
				case (r_reg.xf)
					XF_TX: n.sda_oe_n = (r_reg.bitn == `IMAC_ACK_BIT)
						|| r_reg.sh[7];
					XF_ACK: n.sda_oe_n = r_reg.ack_data;
					default: n.sda_oe_n = 1'b1;
				endcase
				if (tick) begin
					n.scl_oe_n = 1'b1;
					n.st = ST_B_REL;
				end
			end
			ST_B_REL: begin
				if (r_reg.scl) begin
					n.cnt = r_reg.rate_reload;
					n.st = ST_B_HIGH;
				end
			end
			ST_B_HIGH: begin
				if (r_reg.xf == XF_TX && r_reg.bitn != `IMAC_ACK_BIT
					&& r_reg.sh[7] && !r_reg.sda) begin
					coll = 1'b1;
				end else if (r_reg.xf == XF_ACK && r_reg.ack_data
					&& !r_reg.sda) begin
					coll = 1'b1;
				end else if (tick) begin
					n.scl_oe_n = 1'b0;
					n.cnt = r_reg.rate_reload;
					n.bitn = r_reg.bitn + 4'h1;
					n.sh = {r_reg.sh[6:0], r_reg.sda};
					n.st = ST_B_LOW;
					case (r_reg.xf)
						XF_TX: begin
							if (r_reg.bitn == `IMAC_LAST_BIT) begin
								n.buffer_full_flag = 1'b0;
							end
							if (r_reg.bitn == `IMAC_ACK_BIT) begin
								n.ackstat = r_reg.sda;
								done = 1'b1;
								n.st = ST_IDLE;
							end
						end
						XF_RX: begin
							if (r_reg.bitn == `IMAC_LAST_BIT) begin
								n.shift_buffer = {r_reg.sh[6:0], r_reg.sda};
								n.buffer_full_flag = 1'b1;
								n.rcv_en = 1'b0;
								done = 1'b1;
								n.st = ST_IDLE;
							end
						end
						default: begin
							n.ack_en = 1'b0;
							done = 1'b1;
							n.st = ST_IDLE;
						end
					endcase
				end
			end
			default: n.st = ST_IDLE;
		endcase

		if (coll) begin
			n = imac_collide(n);
		end
		if (done || stop_ev) begin
			n.port_event_flag = 1'b1;
		end

		// disabled port holds nothing in flight
		if (!n.en) begin
			n.st = ST_IDLE;
			n.scl_oe_n = 1'b1;
			n.sda_oe_n = 1'b1;
			n.start_seen = 1'b0;
			n.stop_seen = 1'b0;
			n.start_en = 1'b0;
			n.rstart_en = 1'b0;
			n.stop_en = 1'b0;
			n.rcv_en = 1'b0;
			n.ack_en = 1'b0;
			n.buffer_full_flag = 1'b0;
		end
		r_next = n;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
			r_reg.scl_sy <= 3'h7;
			r_reg.sda_sy <= 3'h7;
			r_reg.scl <= 1'b1;
			r_reg.sda <= 1'b1;
			r_reg.st <= ST_IDLE;
			r_reg.xf <= XF_TX;
			r_reg.rate_reload <= `IMAC_RST_RELOAD;
			r_reg.shift_buffer <= `IMAC_RST_BYTE;
			r_reg.scl_oe_n <= 1'b1;
			r_reg.sda_oe_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// outputs
	assign wb_rsp_o.ack = r_reg.ack;
	assign wb_rsp_o.dat = r_reg.rdat;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n_o = r_reg.scl_oe_n;
	assign sda_oe_n_o = r_reg.sda_oe_n;
	assign port_irq_o = r_reg.port_event_flag && r_reg.ie;
	assign wake_o = port_irq_o && sleep_i;

endmodule
`default_nettype wire
